// ==== logic/deep_sleep_pkg.sv ====
// Constants shared by the deep sleep controller and its helpers
package deep_sleep_pkg;
  // Register indexes; the APB byte address is four times the index
  localparam logic [11:0] IDX_WAKE_LOW   = 12'hf4a;
  localparam logic [11:0] IDX_WAKE_HIGH  = 12'hf4b;
  localparam logic [11:0] IDX_SLEEP_LOW  = 12'hf4c;
  localparam logic [11:0] IDX_SLEEP_HIGH = 12'hf4d;
  localparam logic [11:0] IDX_SCRATCH_0  = 12'hf4e;
  localparam logic [11:0] IDX_WDT_CTRL   = 12'hf50;
  localparam logic [11:0] IDX_OSC_CTRL   = 12'hf51;
  localparam int          ADDR_W         = 16;

  // Field positions
  localparam int BIT_ARM         = 7;
  localparam int BIT_RESERVED    = 2;
  localparam int BIT_ULP_ON      = 1;
  localparam int BIT_RTC_BLOCK   = 0;
  localparam int BIT_ULP_BLOCK   = 2;
  localparam int BIT_DIP_FLAG    = 1;
  localparam int BIT_RELEASE     = 0;
  localparam int BIT_FAULT       = 7;
  localparam int BIT_ULP_CAUSE   = 5;
  localparam int BIT_WDT_CAUSE   = 4;
  localparam int BIT_RTC_CAUSE   = 3;
  localparam int BIT_MCLR_CAUSE  = 2;
  localparam int BIT_POR_CAUSE   = 0;
  localparam int BIT_INT0_CAUSE  = 0;
  localparam int BIT_REG_SLEEP   = 7;
  localparam int BIT_EXIT_FLAG   = 3;
  localparam int BIT_IDLE_SLEEP  = 7;

  // Values after reset
  localparam logic [7:0] RST_SLEEP_LOW  = 8'h00;
  localparam logic [7:0] RST_SLEEP_HIGH = 8'h00;
  localparam logic [7:0] RST_WAKE_LOW   = 8'h01;
  localparam logic [7:0] RST_WAKE_HIGH  = 8'h00;
  localparam logic [7:0] RST_WDT_CTRL   = 8'h80;
  localparam logic [7:0] RST_OSC_CTRL   = 8'h00;

  // Timing
  localparam int CLK_PERIOD_NS   = 4;
  localparam int INSTR_PERIOD_NS = 16;
  localparam int ARM_LIFE_INSTR  = 2;
  localparam int POR_HOLD_NS     = 64;
  localparam int CLKS_PER_INSTR  = (INSTR_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] ARM_LIFE_CYCLES = 4'(ARM_LIFE_INSTR * CLKS_PER_INSTR);
  localparam logic [4:0] POR_HOLD_CYCLES =
    5'((POR_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  localparam int PIN_COUNT  = 8;
  localparam int WAKE_INPUTS = 9;

  typedef enum logic [1:0] {
    ST_AWAKE      = 2'b00,
    ST_ARMED      = 2'b01,
    ST_DEEP_SLEEP = 2'b11,
    ST_WAKE_RESET = 2'b10
  } sleep_state_type;
endpackage : deep_sleep_pkg

// ==== logic/sync_2ff.sv ====
// Two flip-flop synchroniser for a group of asynchronous levels
`timescale 1ns/1ps
module sync_2ff #(
  parameter int WIDTH = 1
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] stage;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage <= '0;
      q     <= '0;
    end else begin
      stage <= d;
      q     <= stage;
    end
  end
endmodule : sync_2ff

// ==== logic/pin_hold.sv ====
// I/O pin state hold: freezes direction and level while held
`timescale 1ns/1ps
module pin_hold #(
  parameter int WIDTH = 8
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             capture,
  input  wire logic             hold,
  input  wire logic [WIDTH-1:0] direction,
  input  wire logic [WIDTH-1:0] latch,
  output logic      [WIDTH-1:0] pin_out,
  output logic      [WIDTH-1:0] pin_oe
);
  logic [WIDTH-1:0] held_dir;
  logic [WIDTH-1:0] held_level;

  // Direction bit set means input, so the pin floats
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      held_dir   <= '1;
      held_level <= '0;
    end else if (capture) begin
      held_dir   <= direction;
      held_level <= latch;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out <= '0;
      pin_oe  <= '0;
    end else if (hold && !capture) begin
      pin_out <= held_level;
      pin_oe  <= ~held_dir;
    end else if (!hold) begin
      pin_out <= latch;
      pin_oe  <= ~direction;
    end
  end
endmodule : pin_hold

// ==== logic/deep_sleep_controller.sv ====
// Deep sleep controller: entry handshake, wake gating, pin hold and scratch
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
// Notes on behaviour
// [RULE_01] Calendar keeps running and may wake
// [RULE_02] Config bit picks calendar reference clock
// [RULE_03] Firmware sets regulator sleep, clears idle
// [RULE_04] Firmware waits for calendar rollover to finish
// [RULE_05] Arm bit then sleep command, back to back
// [RULE_06] Every wake runs a power-on reset
// [RULE_07] Exit flag set on wake, firmware clears
// [RULE_08] Fault in deep sleep flags and wakes
// [RULE_09] Fault watch needs no enable
// [RULE_10] Arm bit picks deep or ordinary sleep
// [RULE_11] High bits 6-3 read zero, bit 2 reserved
// [RULE_12] Module-on bit powers ultra-low-power wake
// [RULE_13] Block bit stops calendar alarm wake
// [RULE_14] Ultra-low-power wake needs block clear, module on
// [RULE_15] Dip flag when armed level crossed, not trip
// [RULE_16] Pins held after wake until release cleared
// [RULE_17] Dip flag and release clear at power-up
// [RULE_18] Scratch byte kept through sleep and wake
// [RULE_19] Scratch lost on brownout, trip or cycling; code clears it on brownout only outside deep sleep, on trip only in deep sleep
// [RULE_20] Firmware reads wake causes and dip flag
// [RULE_21] Arm bit self-clears after two instruction cycles
// [RULE_22] Entry clears causes; first wake recorded
// [RULE_23] Held inputs float, held outputs keep level
// [RULE_24] Awake, armed, deep sleep, wake reset states
module deep_sleep_controller
  import deep_sleep_pkg::*;
(
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [ADDR_W-1:0]    paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic                 sleep_cmd,
  input  wire logic                 cfg_rtc_clock_select,
  input  wire logic                 cfg_dip_detector_enable,
  input  wire logic                 rtc_alarm,
  input  wire logic                 ulp_event,
  input  wire logic                 int0_event,
  input  wire logic                 mclr_event,
  input  wire logic                 wdt_timeout,
  input  wire logic                 fault_detect,
  input  wire logic                 supply_below_arm,
  input  wire logic                 supply_below_trip,
  input  wire logic                 core_brownout,
  input  wire logic [PIN_COUNT-1:0] pin_direction_reg,
  input  wire logic [PIN_COUNT-1:0] pin_latch_reg,
  output logic      [PIN_COUNT-1:0] pin_out,
  output logic      [PIN_COUNT-1:0] pin_oe,
  output logic                      core_power_off,
  output logic                      por_request,
  output logic                      ordinary_sleep,
  output logic                      rtc_run,
  output logic                      rtc_source_secondary,
  output logic                      ulp_module_power
);
  sleep_state_type          state;
  sleep_state_type          next_state;
  logic [WAKE_INPUTS-1:0]   async_in;
  logic [WAKE_INPUTS-1:0]   sync_in;
  logic                     s_rtc, s_ulp, s_int0, s_mclr, s_wdt;
  logic                     s_fault, s_arm_lvl, s_trip, s_brown;
  logic                     deep_sleep_arm, ulp_wake_module_on, rtc_wake_block, reserved_bit;
  logic                     ulp_wake_block, dip_event_flag, release_bit;
  logic [7:0]               wake_cause_low, wake_cause_high, persistent_scratch_0;
  logic                     regulator_sleep_select, deep_sleep_exit_flag, idle_on_sleep;
  logic [3:0]               arm_count;
  logic [4:0]               por_count;
  logic                     wr_en, rd_setup, hit;
  logic [11:0]              index;
  logic [7:0]               wdata;
  logic [7:0]               rd_value;
  logic                     enter_deep, wake_any, rtc_ok, ulp_ok, trip_en, leave_deep;

  // Every wake, fault and supply level passes two flops, so a wake is seen two cycles late
  assign async_in = {core_brownout, supply_below_trip, supply_below_arm, fault_detect,
                     wdt_timeout, mclr_event, int0_event, ulp_event, rtc_alarm};

  sync_2ff #(.WIDTH(WAKE_INPUTS)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (async_in),
    .q       (sync_in)
  );

  assign {s_brown, s_trip, s_arm_lvl, s_fault, s_wdt, s_mclr, s_int0, s_ulp, s_rtc} = sync_in;

  // APB decode; registers answer with zero wait states
  assign index    = paddr[13:2];
  assign wdata    = pwdata[7:0];
  assign wr_en    = psel && penable && pwrite && pready && hit;
  assign rd_setup = psel && !penable;
  assign hit      = (paddr[1:0] == 2'b00) && (paddr[ADDR_W-1:14] == 2'b00) &&
                    (index inside {IDX_WAKE_LOW, IDX_WAKE_HIGH, IDX_SLEEP_LOW, IDX_SLEEP_HIGH,
                                   IDX_SCRATCH_0, IDX_WDT_CTRL, IDX_OSC_CTRL});

  // Wake gating
  // A blocked source is ignored outright and never logs a cause
  assign rtc_ok   = s_rtc && !rtc_wake_block;                           // [RULE_01] [RULE_13]
  assign ulp_ok   = s_ulp && ulp_wake_module_on && !ulp_wake_block;     // [RULE_12] [RULE_14]
  assign trip_en  = s_trip && cfg_dip_detector_enable;
  // Fault has no enable term at all
  assign wake_any = s_fault || rtc_ok || ulp_ok || s_int0 || s_mclr || s_wdt || trip_en; // [RULE_09]
  assign leave_deep = (state == ST_DEEP_SLEEP) && wake_any;
  // Regulator select and idle bit are the firmware's part of the entry
  assign enter_deep = (state == ST_ARMED) && sleep_cmd && deep_sleep_arm &&
                      regulator_sleep_select && !idle_on_sleep;        // [RULE_03] [RULE_05] [RULE_10]

  always_comb begin
    next_state = state;
    case (state)
      ST_AWAKE: begin
        if (deep_sleep_arm) next_state = ST_ARMED;
      end
      ST_ARMED: begin
        if (enter_deep) next_state = ST_DEEP_SLEEP;
        else if (sleep_cmd || !deep_sleep_arm) next_state = ST_AWAKE;
      end
      ST_DEEP_SLEEP: begin
        if (wake_any) next_state = ST_WAKE_RESET;                       // [RULE_24]
      end
      ST_WAKE_RESET: begin
        if (por_count == 5'd1) next_state = ST_AWAKE;
      end
      default: next_state = ST_AWAKE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) state <= ST_AWAKE;
    else state <= next_state;
  end

  // Power-on reset request held for a fixed time after any wake
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      por_count   <= '0;
      por_request <= 1'b0;
    end else if (leave_deep) begin
      por_count   <= POR_HOLD_CYCLES;
      por_request <= 1'b1;                                              // [RULE_06] [RULE_08]
    end else if (por_count != '0) begin
      por_count   <= por_count - 5'd1;
      por_request <= (por_count != 5'd1);
    end
  end

  // Arm bit; a stray write cannot linger into a later sleep command
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      deep_sleep_arm <= 1'b0;
      arm_count      <= '0;
    end else if (wr_en && index == IDX_SLEEP_HIGH) begin
      deep_sleep_arm <= wdata[BIT_ARM];
      arm_count      <= wdata[BIT_ARM] ? ARM_LIFE_CYCLES : 4'd0;
    end else if (sleep_cmd || arm_count == 4'd1) begin
      deep_sleep_arm <= 1'b0;                                           // [RULE_21]
      arm_count      <= '0;
    end else if (arm_count != '0) begin
      arm_count <= arm_count - 4'd1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ulp_wake_module_on <= 1'b0;
      rtc_wake_block     <= 1'b0;
      reserved_bit       <= 1'b0;
      ulp_wake_block     <= 1'b0;
    end else if (wr_en && index == IDX_SLEEP_HIGH) begin
      ulp_wake_module_on <= wdata[BIT_ULP_ON];
      rtc_wake_block     <= wdata[BIT_RTC_BLOCK];
      reserved_bit       <= wdata[BIT_RESERVED];
    end else if (wr_en && index == IDX_SLEEP_LOW) begin
      ulp_wake_block <= wdata[BIT_ULP_BLOCK];
    end
  end

  // Dip flag: hardware set wins over a software clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) dip_event_flag <= 1'b0;                               // [RULE_17]
    else if (state == ST_DEEP_SLEEP && cfg_dip_detector_enable && s_arm_lvl && !s_trip)
      dip_event_flag <= 1'b1;                                           // [RULE_15]
    else if (wr_en && index == IDX_SLEEP_LOW) dip_event_flag <= wdata[BIT_DIP_FLAG];
  end

  // Release: set on entry, dropped by firmware, by reset pin or supply trip
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) release_bit <= 1'b0;                                  // [RULE_17]
    else if (enter_deep) release_bit <= 1'b1;                           // [RULE_16]
    else if (leave_deep && (s_mclr || trip_en)) release_bit <= 1'b0;
    else if (wr_en && index == IDX_SLEEP_LOW) release_bit <= wdata[BIT_RELEASE];
  end

  // Wake causes: cleared at entry, only the first source is logged
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_cause_low  <= RST_WAKE_LOW;
      wake_cause_high <= RST_WAKE_HIGH;
    end else if (enter_deep) begin
      wake_cause_low  <= '0;                                            // [RULE_22]
      wake_cause_high <= '0;
    end else if (leave_deep) begin
      // One-hot by priority so simultaneous sources never log twice
      if (s_fault) wake_cause_low[BIT_FAULT] <= 1'b1;                   // [RULE_08]
      else if (trip_en) wake_cause_low[BIT_POR_CAUSE] <= 1'b1;
      else if (s_mclr) wake_cause_low[BIT_MCLR_CAUSE] <= 1'b1;
      else if (s_wdt) wake_cause_low[BIT_WDT_CAUSE] <= 1'b1;
      else if (rtc_ok) wake_cause_low[BIT_RTC_CAUSE] <= 1'b1;           // [RULE_22]
      else if (ulp_ok) wake_cause_low[BIT_ULP_CAUSE] <= 1'b1;
      else wake_cause_high[BIT_INT0_CAUSE] <= 1'b1;
    end else if (wr_en && index == IDX_WAKE_LOW) begin
      wake_cause_low <= wdata & 8'hbd;
    end else if (wr_en && index == IDX_WAKE_HIGH) begin
      wake_cause_high <= wdata & 8'h01;
    end
  end

  // Exit flag: a wake beats a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      regulator_sleep_select <= RST_WDT_CTRL[BIT_REG_SLEEP];
      deep_sleep_exit_flag   <= RST_WDT_CTRL[BIT_EXIT_FLAG];
      idle_on_sleep          <= RST_OSC_CTRL[BIT_IDLE_SLEEP];
    end else begin
      if (leave_deep) deep_sleep_exit_flag <= 1'b1;                     // [RULE_07]
      else if (wr_en && index == IDX_WDT_CTRL) deep_sleep_exit_flag <= wdata[BIT_EXIT_FLAG];
      if (wr_en && index == IDX_WDT_CTRL) regulator_sleep_select <= wdata[BIT_REG_SLEEP];
      if (wr_en && index == IDX_OSC_CTRL) idle_on_sleep <= wdata[BIT_IDLE_SLEEP];
    end
  end

  // Scratch has no reset: its power-up value is undefined by design
  always_ff @(posedge pclk) begin
    if ((s_brown && state != ST_DEEP_SLEEP) || (trip_en && state == ST_DEEP_SLEEP))
      persistent_scratch_0 <= '0;                                       // [RULE_19]
    else if (wr_en && index == IDX_SCRATCH_0)
      persistent_scratch_0 <= wdata;                                    // [RULE_18]
  end

  always_comb begin
    rd_value = 8'h00;
    case (index)
      IDX_SLEEP_HIGH: rd_value = {deep_sleep_arm, 4'b0000, reserved_bit,
                                  ulp_wake_module_on, rtc_wake_block};  // [RULE_11]
      IDX_SLEEP_LOW:  rd_value = {5'b00000, ulp_wake_block, dip_event_flag, release_bit};
      IDX_SCRATCH_0:  rd_value = persistent_scratch_0;
      IDX_WAKE_LOW:   rd_value = wake_cause_low;
      IDX_WAKE_HIGH:  rd_value = wake_cause_high;
      IDX_WDT_CTRL:   rd_value = {regulator_sleep_select, 3'b000, deep_sleep_exit_flag, 3'b000};
      IDX_OSC_CTRL:   rd_value = {idle_on_sleep, 7'b0000000};
      default:        rd_value = 8'h00;
    endcase
  end

  // Read data is latched in the setup cycle so pready can stay high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= '0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= 1'b1;
      if (rd_setup) begin
        prdata  <= {24'h00_0000, rd_value};
        pslverr <= !hit;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_power_off       <= 1'b0;
      ordinary_sleep       <= 1'b0;
      rtc_run              <= 1'b0;
      rtc_source_secondary <= 1'b0;
      ulp_module_power     <= 1'b0;
    end else begin
      core_power_off       <= (next_state == ST_DEEP_SLEEP);
      ordinary_sleep       <= sleep_cmd && !enter_deep;                 // [RULE_10]
      rtc_run              <= 1'b1;                                     // [RULE_01]
      rtc_source_secondary <= cfg_rtc_clock_select;                     // [RULE_02]
      ulp_module_power     <= ulp_wake_module_on;                       // [RULE_12]
    end
  end

  pin_hold #(.WIDTH(PIN_COUNT)) u_pins (
    .pclk      (pclk),
    .presetn   (presetn),
    .capture   (enter_deep),                                            // [RULE_23]
    .hold      (release_bit),                                           // [RULE_16]
    .direction (pin_direction_reg),
    .latch     (pin_latch_reg),
    .pin_out   (pin_out),
    .pin_oe    (pin_oe)
  );

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_arm_expires: assert property ($rose(deep_sleep_arm) && !sleep_cmd |->   // [RULE_21]
    ##[1:9] !deep_sleep_arm) else $error("arm bit did not self-clear");
  a_deep_needs_arm: assert property ($rose(core_power_off) |->               // [RULE_10]
    $past(deep_sleep_arm)) else $error("deep sleep without arm bit");
  a_wake_por: assert property (leave_deep |=> por_request[*8])               // [RULE_06]
    else $error("wake did not hold reset request");
  a_exit_flag: assert property (leave_deep |=> deep_sleep_exit_flag)         // [RULE_07]
    else $error("exit flag not set on wake");
  a_fault_wake: assert property (state == ST_DEEP_SLEEP && s_fault |=>       // [RULE_08]
    wake_cause_low[BIT_FAULT] && state == ST_WAKE_RESET) else $error("fault not handled");
  a_rtc_blocked: assert property (state == ST_DEEP_SLEEP && rtc_wake_block && // [RULE_13]
    $stable(wake_cause_low) |=> !wake_cause_low[BIT_RTC_CAUSE]) else $error("blocked alarm woke");
  a_ulp_gated: assert property (leave_deep && !s_fault && !trip_en && !s_mclr && !s_wdt &&
    !rtc_ok && ulp_ok |=> wake_cause_low[BIT_ULP_CAUSE]) else $error("ulp wake lost"); // [RULE_14]
  a_causes_clear: assert property (enter_deep |=> wake_cause_low == 8'h00 && // [RULE_22]
    wake_cause_high == 8'h00) else $error("causes not cleared on entry");
  a_release_set: assert property (enter_deep |=> release_bit ##1 pin_oe == $past(~pin_direction_reg, 2))
    else $error("pins not held on entry");                                   // [RULE_23]
  a_high_zero: assert property (psel && !penable && index == IDX_SLEEP_HIGH |=> // [RULE_11]
    prdata[6:3] == 4'b0000) else $error("unimplemented bits not zero");
  a_ordinary_sleep: assert property (sleep_cmd && !enter_deep |=> ordinary_sleep) // [RULE_10]
    else $error("ordinary sleep pulse missing");
  a_dip_set: assert property (state == ST_DEEP_SLEEP && cfg_dip_detector_enable && // [RULE_15]
    s_arm_lvl && !s_trip |=> dip_event_flag) else $error("dip event not flagged");
  a_mclr_release: assert property (leave_deep && s_mclr |=> !release_bit) // [RULE_16]
    else $error("reset pin wake did not release pins");
  a_trip_release: assert property (leave_deep && trip_en |=> !release_bit) // [RULE_16]
    else $error("supply trip did not release pins");

  c_deep_entry: cover property (enter_deep);
  c_fault_exit: cover property (leave_deep && s_fault);
  c_arm_lapse:  cover property (state == ST_ARMED ##1 state == ST_AWAKE && !sleep_cmd);
  c_dip_flag:   cover property ($rose(dip_event_flag));
  c_ulp_exit:   cover property (leave_deep && ulp_ok && !s_fault);
endmodule : deep_sleep_controller

// ==== tb/deep_sleep_controller_tb.sv ====
// Self-checking bench for the deep sleep controller
`timescale 1ns/1ps
module deep_sleep_controller_tb
  import deep_sleep_pkg::*;
;
  localparam logic [15:0] A_WAKE = 16'({IDX_WAKE_LOW, 2'h0});
  localparam logic [15:0] A_LOW  = 16'({IDX_SLEEP_LOW, 2'h0});
  localparam logic [15:0] A_HIGH = 16'({IDX_SLEEP_HIGH, 2'h0});
  localparam logic [15:0] A_SCR  = 16'({IDX_SCRATCH_0, 2'h0});
  localparam logic [15:0] A_WDT  = 16'({IDX_WDT_CTRL, 2'h0});
  localparam logic [15:0] A_OSC  = 16'({IDX_OSC_CTRL, 2'h0});

  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        sleep_cmd = 1'b0, rtc_sel = 1'b0, dip_en = 1'b1, sup_arm = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [5:0]  ev = 6'h00;
  logic [7:0]  dir = 8'h00, drive_level = 8'h00, rd;
  logic        brown = 1'b0, trip = 1'b0;
  logic [31:0] prdata;
  logic [7:0]  pin_out, pin_oe;
  logic        pready, pslverr, err, core_power_off, por_request, ordinary_sleep;
  logic        rtc_run, rtc_src, ulp_pwr;
  int          n_fail = 0;
  int          checks_done = 0;

  always #2 pclk = ~pclk;

  // Trip and brownout are driven only in the scratch-loss scenario
  deep_sleep_controller dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sleep_cmd(sleep_cmd), .cfg_rtc_clock_select(rtc_sel), .cfg_dip_detector_enable(dip_en),
    .rtc_alarm(ev[0]), .ulp_event(ev[1]), .fault_detect(ev[2]), .mclr_event(ev[3]),
    .wdt_timeout(ev[4]), .int0_event(ev[5]), .supply_below_arm(sup_arm),
    .supply_below_trip(trip), .core_brownout(brown), .pin_direction_reg(dir),
    .pin_latch_reg(drive_level), .pin_out(pin_out), .pin_oe(pin_oe),
    .core_power_off(core_power_off), .por_request(por_request),
    .ordinary_sleep(ordinary_sleep), .rtc_run(rtc_run), .rtc_source_secondary(rtc_src),
    .ulp_module_power(ulp_pwr)
  );

  task close_out;
    $display("checks %0d errors %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : close_out

  task chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task apb(input logic w, input logic [15:0] a, input logic [7:0] d);
    int i;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 16);
    if (pready !== 1'b1) begin
      chk(8'h00, 8'h01, "bus hang");
      close_out();
    end
    rd = prdata[7:0];
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Samples just after an edge so one-cycle pulses are not missed
  task wait_for(input int sel, input logic lvl, input int lim);
    int   i;
    logic s;
    for (i = 0; i < lim; i++) begin
      #1;
      s = (sel == 0) ? core_power_off : (sel == 1) ? por_request : ordinary_sleep;
      if (s === lvl) return;
      @(posedge pclk);
    end
    chk(8'h00, 8'h01, "wait bound");
    close_out();
  endtask : wait_for

  task sleep_now;
    @(posedge pclk);
    sleep_cmd <= 1'b1;
    @(posedge pclk);
    sleep_cmd <= 1'b0;
  endtask : sleep_now

  task t_reset;
    apb(0, A_LOW, 8'h00);
    chk(rd, RST_SLEEP_LOW, "low reset");
    apb(0, A_WAKE, 8'h00);
    chk(rd, RST_WAKE_LOW, "cause reset");
    apb(0, A_WDT, 8'h00);
    chk(rd, RST_WDT_CTRL, "wdt reset");
    apb(1, 16'h0100, 8'h55);
    chk({7'h00, err}, 8'h01, "unmapped");
    apb(1, A_HIGH, 8'h7B);
    apb(0, A_HIGH, 8'h00);
    chk(rd, 8'h03, "high readback");
    chk({7'h00, ulp_pwr}, 8'h01, "ulp power");
    rtc_sel <= 1'b1;
    apb(1, A_HIGH, 8'h00);
    chk({6'h00, rtc_run, rtc_src}, 8'h03, "rtc clock");
  endtask : t_reset

  task t_expiry;
    apb(1, A_OSC, 8'h80);
    apb(1, A_HIGH, 8'h80);
    sleep_now;
    wait_for(2, 1'b1, 3);
    chk({7'h00, core_power_off}, 8'h00, "idle blocks deep");
    apb(1, A_OSC, 8'h00);
    apb(1, A_HIGH, 8'h80);
    repeat (12) @(posedge pclk);
    sleep_now;
    wait_for(2, 1'b1, 3);
    chk({7'h00, core_power_off}, 8'h00, "late sleep");
    apb(0, A_HIGH, 8'h00);
    chk(rd, 8'h00, "arm cleared");
  endtask : t_expiry

  task sleep_cycle(input logic [7:0] hi, input logic [7:0] lo, input logic [5:0] blk,
                   input logic [5:0] wk, input logic [7:0] exp);
    apb(1, A_WDT, 8'h80);
    apb(1, A_OSC, 8'h00);
    apb(1, A_LOW, lo);
    apb(1, A_HIGH, hi);
    sleep_now;
    wait_for(0, 1'b1, 3);
    @(posedge pclk);
    ev <= blk;
    sup_arm <= 1'b1;
    repeat (8) @(posedge pclk);
    #1;
    chk({7'h00, core_power_off}, 8'h01, "blocked wake");
    @(posedge pclk);
    ev <= wk;
    sup_arm <= 1'b0;
    wait_for(1, 1'b1, 8);
    chk({7'h00, core_power_off}, 8'h00, "power back");
    @(posedge pclk);
    ev <= 6'h00;
    wait_for(1, 1'b0, 24);
    apb(0, A_WAKE, 8'h00);
    chk(rd, exp, "wake cause");
  endtask : sleep_cycle

  task t_after;
    dir <= 8'h00;
    drive_level <= 8'hFF;
    apb(0, A_SCR, 8'h00);
    chk(rd, 8'hA5, "scratch kept");
    chk(pin_oe, 8'h0F, "pins held oe");
    chk(pin_out & 8'h0F, 8'h0A, "pins held lvl");
    apb(0, A_LOW, 8'h00);
    chk(rd & 8'h03, 8'h03, "dip and release");
    apb(0, A_WDT, 8'h00);
    chk(rd & 8'h08, 8'h08, "exit flag");
    apb(1, A_WDT, 8'h80);
    apb(0, A_WDT, 8'h00);
    chk(rd & 8'h08, 8'h00, "exit cleared");
    apb(1, A_LOW, 8'h00);
    @(posedge pclk);
    #1;
    chk(pin_oe, 8'hFF, "released oe");
    chk(pin_out, 8'hFF, "released lvl");
  endtask : t_after

  task t_loss;
    apb(1, A_SCR, 8'h3C);
    brown <= 1'b1;
    repeat (4) @(posedge pclk);
    brown <= 1'b0;
    apb(0, A_SCR, 8'h00);
    chk(rd, 8'h00, "scratch lost on brownout");
    apb(1, A_SCR, 8'h3C);
    apb(1, A_HIGH, 8'h80);
    sleep_now;
    wait_for(0, 1'b1, 3);
    @(posedge pclk);
    trip <= 1'b1;
    wait_for(1, 1'b1, 8);
    @(posedge pclk);
    trip <= 1'b0;
    wait_for(1, 1'b0, 24);
    apb(0, A_SCR, 8'h00);
    chk(rd, 8'h00, "scratch lost on trip");
    apb(0, A_WAKE, 8'h00);
    chk(rd, 8'h01, "trip cause");
    apb(0, A_LOW, 8'h00);
    chk(rd & 8'h01, 8'h00, "trip released pins");
  endtask : t_loss

  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_expiry;
    dir <= 8'hF0;
    drive_level <= 8'h5A;
    apb(1, A_SCR, 8'hA5);
    sleep_cycle(8'h81, 8'h00, 6'h01, 6'h04, 8'h80);
    t_after;
    sleep_cycle(8'h83, 8'h04, 6'h02, 6'h08, 8'h04);
    sleep_cycle(8'h80, 8'h00, 6'h02, 6'h01, 8'h08);
    sleep_cycle(8'h82, 8'h00, 6'h00, 6'h02, 8'h20);
    sleep_cycle(8'h80, 8'h00, 6'h00, 6'h10, 8'h10);
    t_loss;
    close_out();
  end
endmodule : deep_sleep_controller_tb
